// *** design/freewheel_if.sv ***
// Signals between the address engine and the freewheel timer
`timescale 1ns/1ps
`default_nettype none
interface freewheel_if;
   logic code_ok;
   logic drop;
   logic tick;
   logic bypass;
   logic [5:0] length;
   logic active;

   modport ctrl (output code_ok, output drop, output tick, output bypass, output length,
                 input active);
   modport timer (input code_ok, input drop, input tick, input bypass, input length,
                  output active);
endinterface
`default_nettype wire

// *** design/freewheel_timer.sv ***
// Freewheel frame timer: limits how long the address runs on after code loss
`timescale 1ns/1ps
`default_nettype none
module freewheel_timer (
   input wire logic pclk,
   input wire logic presetn,
   freewheel_if.timer fw
);
   logic active_q;
   logic [5:0] count_q;

   assign fw.active = active_q;

   // Start on dropout, end on code return or when the length is used up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_q <= 1'b0;
         count_q <= 6'h00;
      end else if (fw.code_ok || fw.bypass) begin
         active_q <= 1'b0;
         count_q <= 6'h00;
      end else if (fw.drop) begin
         active_q <= 1'b1;
         count_q <= 6'h00;
      end else if (active_q && fw.tick) begin
         count_q <= count_q + 6'h01;
         if (count_q + 6'h01 >= fw.length) begin
            active_q <= 1'b0;
         end
      end
   end
endmodule // freewheel_timer
`default_nettype wire

// *** design/pos_ref_pkg.sv ***
// Constants, register map and mode types for the positional reference selector
package pos_ref_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FW_LEN = 8'h04;
   localparam logic [7:0] OFS_PPF = 8'h08;
   localparam logic [7:0] OFS_PRESET = 8'h0c;
   localparam logic [7:0] OFS_TRIM = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_ADDR = 8'h18;

   // Control register fields
   localparam int CTRL_POS_LSB = 0;
   localparam int CTRL_CLK_LSB = 4;
   localparam int CTRL_RUN_BIT = 8;

   // Trim register fields (write-only strobes)
   localparam int TRIM_UP_BIT = 0;
   localparam int TRIM_DN_BIT = 1;

   // Status register fields
   localparam int ST_VALID_BIT = 0;
   localparam int ST_FREE_BIT = 1;
   localparam int ST_VITC_BIT = 2;
   localparam int ST_LOCK_BIT = 3;

   // Setting limits and reset values
   localparam logic [7:0] FW_MIN = 8'h04;
   localparam logic [7:0] FW_MAX = 8'h28;
   localparam logic [7:0] FW_RESET = 8'h0a;
   localparam logic [7:0] PPF_MIN = 8'h02;
   localparam logic [7:0] PPF_MAX = 8'hfe;
   localparam logic [7:0] PPF_RESET = 8'h04;

   // Positional reference modes
   typedef enum logic [2:0] {
      POS_LTC,
      POS_VITC,
      POS_AUTO,
      POS_PULSE,
      POS_GEN
   } pos_mode_e;

   // Clock references
   typedef enum logic [2:0] {
      CK_INTERNAL,
      CK_LTC,
      CK_VIDEO_REF,
      CK_VIDEO_IN,
      CK_PULSE
   } clk_ref_e;

   // Tracking states of the address engine
   typedef enum logic [2:0] {
      TRK_NOCODE,
      TRK_READ,
      TRK_FREE,
      TRK_GEN,
      TRK_PULSE
   } track_e;

endpackage

// *** design/positional_reference_selector.sv ***
// Positional reference selector with freewheel, auto switch and pulse position
// Overview of operation
// - On code dropout, keep producing addresses for at most the freewheel length.
// - Freewheel ends when code returns or the length in frames has elapsed.
// - Freewheel length is ignored in internal clock with generate mode.
// - Freewheel length setting is held between 4 and 40 frames.
// - LTC may be positional and clock reference at the same time.
// - Auto switch picks whichever of LTC and VITC gives better code.
// - Auto switch lights both source indicators and the minutes/seconds point.
// - Auto switch favours VITC when slow or parked, LTC at shuttle speed.
// - Pulse mode address comes from a start address and pulses per frame.
// - Video reference clock stays locked to burst even without picture.
// - Pulses per frame setting is held between 2 and 254.
// - In pulse mode each up trim adds a frame, a down trim removes one unless written with an up trim.
`timescale 1ns/1ps
`default_nettype none
module positional_reference_selector #(
   parameter int ADDR_W = 24
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic frame_tick,
   input wire logic ltc_valid,
   input wire logic [ADDR_W-1:0] ltc_addr,
   input wire logic vitc_valid,
   input wire logic [ADDR_W-1:0] vitc_addr,
   input wire logic shuttle_fast,
   input wire logic pulse_tick,
   input wire logic pulse_fwd,
   input wire logic pulse_present,
   input wire logic ref_burst_ok,
   input wire logic video_in_ok,
   output logic [ADDR_W-1:0] time_addr,
   output logic addr_valid,
   output logic freewheel,
   output logic ltc_led,
   output logic vitc_led,
   output logic mmss_dp,
   output logic clk_locked
);

   // Clamp a setting into its legal range
   function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
      if (v < lo) begin
         return lo;
      end else if (v > hi) begin
         return hi;
      end else begin
         return v;
      end
   endfunction

   pos_ref_pkg::pos_mode_e pos_mode_q;
   pos_ref_pkg::clk_ref_e clk_ref_q;
   pos_ref_pkg::track_e state_q;
   logic gen_run_q;
   logic [7:0] fw_len_q;
   logic [7:0] ppf_q;
   logic [ADDR_W-1:0] preset_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0] pulse_cnt_q;
   logic use_vitc_q;
   logic valid_q;
   logic free_q;
   logic ltc_led_q;
   logic vitc_led_q;
   logic dp_q;
   logic locked_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic setup;
   logic wr_en;
   logic mapped;
   logic sel_ok;
   logic [ADDR_W-1:0] sel_addr;
   logic trim_up;
   logic trim_dn;
   logic preset_wr;
   logic [31:0] status_w;

   freewheel_if fw ();

   freewheel_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .fw(fw)
   );

   // Bus decode: registered answer one cycle after setup
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && pready_q;
   assign mapped = (paddr == pos_ref_pkg::OFS_CTRL) || (paddr == pos_ref_pkg::OFS_FW_LEN) ||
                   (paddr == pos_ref_pkg::OFS_PPF) || (paddr == pos_ref_pkg::OFS_PRESET) ||
                   (paddr == pos_ref_pkg::OFS_TRIM) || (paddr == pos_ref_pkg::OFS_STATUS) ||
                   (paddr == pos_ref_pkg::OFS_ADDR);
   assign trim_up = wr_en && (paddr == pos_ref_pkg::OFS_TRIM) && pwdata[pos_ref_pkg::TRIM_UP_BIT];
   assign trim_dn = wr_en && (paddr == pos_ref_pkg::OFS_TRIM) && pwdata[pos_ref_pkg::TRIM_DN_BIT];
   assign preset_wr = wr_en && (paddr == pos_ref_pkg::OFS_PRESET);

   // Status word
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[pos_ref_pkg::ST_VALID_BIT] = valid_q;
      status_w[pos_ref_pkg::ST_FREE_BIT] = free_q;
      status_w[pos_ref_pkg::ST_VITC_BIT] = use_vitc_q;
      status_w[pos_ref_pkg::ST_LOCK_BIT] = locked_q;
   end

   // Handshake and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         if (setup && !pwrite) begin
            case (paddr)
               pos_ref_pkg::OFS_CTRL: prdata_q <= {23'h000000, gen_run_q, 1'b0,
                                                   3'(clk_ref_q), 1'b0, 3'(pos_mode_q)};
               pos_ref_pkg::OFS_FW_LEN: prdata_q <= {24'h000000, fw_len_q};
               pos_ref_pkg::OFS_PPF: prdata_q <= {24'h000000, ppf_q};
               pos_ref_pkg::OFS_PRESET: prdata_q <= 32'(preset_q);
               pos_ref_pkg::OFS_STATUS: prdata_q <= status_w;
               pos_ref_pkg::OFS_ADDR: prdata_q <= 32'(addr_q);
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Settings written by software; out-of-range codes keep the old mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_mode_q <= pos_ref_pkg::POS_LTC;
         clk_ref_q <= pos_ref_pkg::CK_INTERNAL;
         gen_run_q <= 1'b0;
         fw_len_q <= pos_ref_pkg::FW_RESET;
         ppf_q <= pos_ref_pkg::PPF_RESET;
         preset_q <= '0;
      end else if (wr_en) begin
         case (paddr)
            pos_ref_pkg::OFS_CTRL: begin
               if (pwdata[pos_ref_pkg::CTRL_POS_LSB +: 3] <= 3'(pos_ref_pkg::POS_GEN)) begin
                  pos_mode_q <= pos_ref_pkg::pos_mode_e'(pwdata[pos_ref_pkg::CTRL_POS_LSB +: 3]);
               end
               if (pwdata[pos_ref_pkg::CTRL_CLK_LSB +: 3] <= 3'(pos_ref_pkg::CK_PULSE)) begin
                  clk_ref_q <= pos_ref_pkg::clk_ref_e'(pwdata[pos_ref_pkg::CTRL_CLK_LSB +: 3]);
               end
               gen_run_q <= pwdata[pos_ref_pkg::CTRL_RUN_BIT];
            end
            pos_ref_pkg::OFS_FW_LEN: fw_len_q <= clamp8(pwdata[7:0], pos_ref_pkg::FW_MIN,
                                                        pos_ref_pkg::FW_MAX);
            pos_ref_pkg::OFS_PPF: ppf_q <= clamp8(pwdata[7:0], pos_ref_pkg::PPF_MIN,
                                                  pos_ref_pkg::PPF_MAX);
            pos_ref_pkg::OFS_PRESET: preset_q <= pwdata[ADDR_W-1:0];
            default: preset_q <= preset_q;
         endcase
      end
   end

   // Auto switch source choice
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         use_vitc_q <= 1'b0;
      end else if (shuttle_fast) begin
         if (ltc_valid) begin
            use_vitc_q <= 1'b0;
         end
      end else if (vitc_valid) begin
         use_vitc_q <= 1'b1;
      end else if (ltc_valid) begin
         use_vitc_q <= 1'b0;
      end
   end

   // Selected incoming code
   always_comb begin
      case (pos_mode_q)
         pos_ref_pkg::POS_LTC: begin
            sel_ok = ltc_valid;
            sel_addr = ltc_addr;
         end
         pos_ref_pkg::POS_VITC: begin
            sel_ok = vitc_valid;
            sel_addr = vitc_addr;
         end
         pos_ref_pkg::POS_AUTO: begin
            sel_ok = use_vitc_q ? vitc_valid : ltc_valid;
            sel_addr = use_vitc_q ? vitc_addr : ltc_addr;
         end
         default: begin
            sel_ok = 1'b0;
            sel_addr = '0;
         end
      endcase
   end

   // Freewheel timer hookup
   assign fw.code_ok = sel_ok;
   assign fw.drop = (state_q == pos_ref_pkg::TRK_READ) && !sel_ok;
   assign fw.tick = frame_tick;
   assign fw.bypass = (pos_mode_q == pos_ref_pkg::POS_GEN) &&
                      (clk_ref_q == pos_ref_pkg::CK_INTERNAL);
   assign fw.length = fw_len_q[5:0];

   // Tracking state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= pos_ref_pkg::TRK_NOCODE;
      end else if (pos_mode_q == pos_ref_pkg::POS_GEN) begin
         state_q <= pos_ref_pkg::TRK_GEN;
      end else if (pos_mode_q == pos_ref_pkg::POS_PULSE) begin
         state_q <= pos_ref_pkg::TRK_PULSE;
      end else begin
         case (state_q)
            pos_ref_pkg::TRK_READ: begin
               if (!sel_ok) begin
                  state_q <= pos_ref_pkg::TRK_FREE;
               end
            end
            pos_ref_pkg::TRK_FREE: begin
               if (sel_ok) begin
                  state_q <= pos_ref_pkg::TRK_READ;
               end else if (!fw.active) begin
                  state_q <= pos_ref_pkg::TRK_NOCODE;
               end
            end
            default: begin
               state_q <= sel_ok ? pos_ref_pkg::TRK_READ : pos_ref_pkg::TRK_NOCODE;
            end
         endcase
      end
   end

   // Time address engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= '0;
         pulse_cnt_q <= 8'h00;
      end else if (preset_wr) begin
         addr_q <= pwdata[ADDR_W-1:0];
         pulse_cnt_q <= 8'h00;
      end else begin
         case (state_q)
            pos_ref_pkg::TRK_READ: addr_q <= sel_ok ? sel_addr : addr_q; // Hold last on loss
            pos_ref_pkg::TRK_FREE: begin
               if (frame_tick && fw.active) begin
                  addr_q <= addr_q + 1'b1;
               end
            end
            pos_ref_pkg::TRK_GEN: begin
               if (frame_tick && gen_run_q) begin
                  addr_q <= addr_q + 1'b1;
               end
            end
            pos_ref_pkg::TRK_PULSE: begin
               if (trim_up) begin
                  addr_q <= addr_q + 1'b1;
               end else if (trim_dn) begin
                  addr_q <= addr_q - 1'b1;
               end else if (pulse_tick && pulse_fwd) begin
                  if (pulse_cnt_q + 8'h01 >= ppf_q) begin
                     pulse_cnt_q <= 8'h00;
                     addr_q <= addr_q + 1'b1;
                  end else begin
                     pulse_cnt_q <= pulse_cnt_q + 8'h01;
                  end
               end else if (pulse_tick) begin
                  if (pulse_cnt_q == 8'h00) begin
                     pulse_cnt_q <= ppf_q - 8'h01;
                     addr_q <= addr_q - 1'b1;
                  end else begin
                     pulse_cnt_q <= pulse_cnt_q - 8'h01;
                  end
               end
            end
            default: addr_q <= addr_q;
         endcase
      end
   end

   // Indicators, validity and clock lock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_q <= 1'b0;
         free_q <= 1'b0;
         ltc_led_q <= 1'b0;
         vitc_led_q <= 1'b0;
         dp_q <= 1'b0;
         locked_q <= 1'b0;
      end else begin
         valid_q <= (state_q == pos_ref_pkg::TRK_READ) || (state_q == pos_ref_pkg::TRK_GEN) ||
                    (state_q == pos_ref_pkg::TRK_PULSE) ||
                    ((state_q == pos_ref_pkg::TRK_FREE) && fw.active);
         free_q <= (state_q == pos_ref_pkg::TRK_FREE) && fw.active;
         ltc_led_q <= (pos_mode_q == pos_ref_pkg::POS_LTC) ||
                      (pos_mode_q == pos_ref_pkg::POS_AUTO);
         vitc_led_q <= (pos_mode_q == pos_ref_pkg::POS_VITC) ||
                       (pos_mode_q == pos_ref_pkg::POS_AUTO);
         dp_q <= pos_mode_q == pos_ref_pkg::POS_AUTO;
         case (clk_ref_q)
            pos_ref_pkg::CK_INTERNAL: locked_q <= 1'b1;
            pos_ref_pkg::CK_LTC: locked_q <= ltc_valid;
            pos_ref_pkg::CK_VIDEO_REF: locked_q <= ref_burst_ok;
            pos_ref_pkg::CK_VIDEO_IN: locked_q <= video_in_ok;
            pos_ref_pkg::CK_PULSE: locked_q <= pulse_present;
            default: locked_q <= 1'b0;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign time_addr = addr_q;
   assign addr_valid = valid_q;
   assign freewheel = free_q;
   assign ltc_led = ltc_led_q;
   assign vitc_led = vitc_led_q;
   assign mmss_dp = dp_q;
   assign clk_locked = locked_q;

endmodule // positional_reference_selector
`default_nettype wire

// *** verification/pos_ref_sva.sv ***
// Assertion checker for the positional reference selector ports
`timescale 1ns/1ps
`default_nettype none
module pos_ref_sva #(
   parameter int ADDR_W = 24
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic frame_tick,
   input wire logic ltc_valid,
   input wire logic [ADDR_W-1:0] ltc_addr,
   input wire logic vitc_valid,
   input wire logic [ADDR_W-1:0] vitc_addr,
   input wire logic shuttle_fast,
   input wire logic ref_burst_ok,
   input wire logic [ADDR_W-1:0] time_addr,
   input wire logic freewheel,
   input wire logic ltc_led,
   input wire logic vitc_led,
   input wire logic mmss_dp,
   input wire logic clk_locked
);
   logic [2:0] mode_q, clk_q, vs_q, ls_q, gi_q, bl_q;
   logic [7:0] fwl_q, tick_q, wd;
   logic [ADDR_W-1:0] trim_q;
   logic wr, rd;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Completed transfers
   assign wr = psel && penable && pready && pwrite;
   assign rd = psel && penable && pready && !pwrite;
   assign wd = pwdata[7:0];
   // Shadow of mode, clock reference and freewheel length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 3'h0;
         clk_q <= 3'h0;
         fwl_q <= pos_ref_pkg::FW_RESET;
      end else if (wr && paddr == pos_ref_pkg::OFS_CTRL) begin
         if (pwdata[2:0] <= 3'h4) mode_q <= pwdata[2:0];
         if (pwdata[6:4] <= 3'h4) clk_q <= pwdata[6:4];
      end else if (wr && paddr == pos_ref_pkg::OFS_FW_LEN) begin
         fwl_q <= (wd < pos_ref_pkg::FW_MIN) ? pos_ref_pkg::FW_MIN :
            ((wd > pos_ref_pkg::FW_MAX) ? pos_ref_pkg::FW_MAX : wd);
      end
   end
   // Frame ticks seen while freewheeling, and address expected after a trim
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_q <= 8'h00;
         trim_q <= '0;
      end else begin
         tick_q <= !freewheel ? 8'h00 : tick_q + 8'(frame_tick);
         if (wr && paddr == pos_ref_pkg::OFS_TRIM)
            trim_q <= pwdata[0] ? time_addr + 1'b1 : time_addr - 1'b1;
      end
   end
   // Conditions held over the last three cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vs_q <= 3'h0;
         ls_q <= 3'h0;
         gi_q <= 3'h0;
         bl_q <= 3'h0;
      end else begin
         vs_q <= {vs_q[1:0], mode_q == 3'h2 && vitc_valid && !shuttle_fast};
         ls_q <= {ls_q[1:0], mode_q == 3'h2 && ltc_valid && shuttle_fast};
         gi_q <= {gi_q[1:0], mode_q == 3'h4 && clk_q == 3'h0};
         bl_q <= {bl_q[1:0], clk_q == 3'h2 && ref_burst_ok};
      end
   end
   fw_limit_a: assert property (freewheel |-> tick_q <= fwl_q)
      else $error("freewheel ran past its frame limit");
   fw_return_a: assert property (freewheel && ltc_valid && ~|mode_q |-> ##[1:3] !freewheel)
      else $error("freewheel held after code returned");
   fw_ignore_a: assert property (&gi_q |-> !freewheel)
      else $error("freewheel in internal generate mode");
   fw_range_a: assert property (rd && paddr == pos_ref_pkg::OFS_FW_LEN |->
      prdata[7:0] >= pos_ref_pkg::FW_MIN && prdata[7:0] <= pos_ref_pkg::FW_MAX)
      else $error("freewheel length outside its range");
   auto_vitc_a: assert property (&vs_q |-> time_addr == $past(vitc_addr, 2))
      else $error("auto mode not following vitc");
   auto_leds_a: assert property (mode_q == 3'h2 && $past(mode_q, 2) == 3'h2 |->
      ltc_led && vitc_led && mmss_dp)
      else $error("auto mode indicators wrong");
   auto_fast_a: assert property (&ls_q |-> time_addr == $past(ltc_addr, 2))
      else $error("auto mode not following ltc at shuttle");
   burst_lock_a: assert property (&bl_q |-> clk_locked)
      else $error("lost lock with burst present");
   trim_step_a: assert property (wr && paddr == pos_ref_pkg::OFS_TRIM && mode_q == 3'h3 &&
      pwdata[1:0] != 2'h0 |-> ##[1:2] time_addr == trim_q)
      else $error("trim did not move address by one frame");
endmodule // pos_ref_sva
bind positional_reference_selector pos_ref_sva #(.ADDR_W(ADDR_W)) sva (.*);
`default_nettype wire

// *** verification/positional_reference_selector_tb.sv ***
// Self-checking bench for the positional reference selector
`timescale 1ns/1ps
`default_nettype none
module positional_reference_selector_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_tick, probe;
   logic ltc_valid, vitc_valid, shuttle_fast, pulse_tick, pulse_fwd, pulse_present;
   logic ref_burst_ok, video_in_ok, addr_valid, freewheel, ltc_led, vitc_led, mmss_dp;
   logic clk_locked, ltc_on, vitc_on, fast, step, fwd;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] src;
   logic [23:0] ltc_addr, vitc_addr, time_addr, base, a;
   logic [32:0] rq[$];
   logic [11:0] pq[$];
   int err_count, compares, p;
   positional_reference_selector DUT (.*);
   transport_model tape (.*);
   // Clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   // Compare each finished read and each port probe with the oldest note
   always @(posedge pclk) begin
      logic [32:0] e;
      logic [11:0] m;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = rq.pop_front();
         compares++;
         if ({pslverr, prdata} !== e) begin
            err_count++;
            $display("unexpected prdata expected %h seen %h", e, {pslverr, prdata});
         end
      end
      if (probe) begin
         m = pq.pop_front();
         compares++;
         if ((({addr_valid, freewheel, ltc_led, vitc_led, mmss_dp, clk_locked} ^ m[5:0])
              & m[11:6]) !== 6'h00) begin
            err_count++;
            $display("unexpected ports expected %h seen %b%b%b%b%b%b", m, addr_valid,
                     freewheel, ltc_led, vitc_led, mmss_dp, clk_locked);
         end
      end
   end
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                      input logic [32:0] e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      if (!w) rq.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         $display("unexpected pready expected 1 seen %b", pready);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d, 33'h0);
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] v);
      apb(1'b0, ad, 32'h0, {1'b0, v});
   endtask
   task automatic chk(input logic [5:0] m, input logic [5:0] v);
      pq.push_back({m, v});
      probe <= 1'b1;
      @(posedge pclk);
      probe <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic code(input logic l, input logic v);
      ltc_on <= l;
      vitc_on <= v;
      idle(4);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         frame_tick <= 1'b1;
         @(posedge pclk);
         frame_tick <= 1'b0;
         idle(2);
      end
   endtask
   task automatic pulse(input int n, input logic f);
      repeat (n) begin
         fwd <= f;
         step <= 1'b1;
         @(posedge pclk);
         step <= 1'b0;
         idle($urandom_range(3, 1));
      end
      idle(3);
   endtask
   task automatic summarize;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog
   initial begin
      #400000;
      err_count++;
      $display("unexpected watchdog expected done seen timeout");
      summarize();
   end
   // Main sequence
   initial begin
      {psel, penable, pwrite, frame_tick, probe, ltc_on, vitc_on, fast, step, fwd} = '0;
      {paddr, pwdata, src, base} = '0;
      presetn = 1'b0;
      void'($urandom(10464));
      idle(12);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(6'h1f, 6'h09);
      rd(pos_ref_pkg::OFS_CTRL, 32'h0);
      rd(pos_ref_pkg::OFS_FW_LEN, 32'(pos_ref_pkg::FW_RESET));
      rd(pos_ref_pkg::OFS_PPF, 32'(pos_ref_pkg::PPF_RESET));
      rd(pos_ref_pkg::OFS_STATUS, 32'h8);
      apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
      wr(pos_ref_pkg::OFS_FW_LEN, 32'h3);
      rd(pos_ref_pkg::OFS_FW_LEN, 32'h4);
      wr(pos_ref_pkg::OFS_FW_LEN, 32'h29);
      rd(pos_ref_pkg::OFS_FW_LEN, 32'h28);
      wr(pos_ref_pkg::OFS_PPF, 32'h1);
      rd(pos_ref_pkg::OFS_PPF, 32'h2);
      wr(pos_ref_pkg::OFS_PPF, 32'hff);
      rd(pos_ref_pkg::OFS_PPF, 32'hfe);
      p = $urandom_range(40, 4);
      wr(pos_ref_pkg::OFS_FW_LEN, 32'(p));
      rd(pos_ref_pkg::OFS_FW_LEN, 32'(p));
      // Freewheel to the limit, then cut short by returning code
      base = 24'($urandom());
      wr(pos_ref_pkg::OFS_FW_LEN, 32'h4);
      code(1'b1, 1'b0);
      code(1'b0, 1'b0);
      chk(6'h30, 6'h30);
      tick(3);
      chk(6'h10, 6'h10);
      tick(1);
      idle(3);
      chk(6'h30, 6'h00);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, base + 24'h000004});
      code(1'b1, 1'b0);
      code(1'b0, 1'b0);
      tick(2);
      code(1'b1, 1'b0);
      chk(6'h30, 6'h20);
      code(1'b0, 1'b0);
      tick(3);
      chk(6'h10, 6'h10);
      tick(1);
      idle(3);
      chk(6'h10, 6'h00);
      // Internal generate keeps counting past the freewheel length
      code(1'b1, 1'b0);
      wr(pos_ref_pkg::OFS_CTRL, 32'h104);
      a = 24'($urandom());
      wr(pos_ref_pkg::OFS_PRESET, {8'h00, a});
      code(1'b0, 1'b0);
      tick(5);
      chk(6'h10, 6'h00);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, a + 24'h000005});
      // Vitc, then auto switching
      base = 24'($urandom());
      wr(pos_ref_pkg::OFS_CTRL, 32'h1);
      code(1'b1, 1'b1);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, base + 24'h000100});
      wr(pos_ref_pkg::OFS_CTRL, 32'h2);
      chk(6'h2e, 6'h2e);
      rd(pos_ref_pkg::OFS_STATUS, 32'hd);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, base + 24'h000100});
      fast <= 1'b1;
      idle(4);
      rd(pos_ref_pkg::OFS_STATUS, 32'h9);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, base});
      fast <= 1'b0;
      code(1'b1, 1'b0);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, base});
      chk(6'h2e, 6'h2e);
      // Pulse position, reverse step and trims
      wr(pos_ref_pkg::OFS_CTRL, 32'h3);
      p = $urandom_range(9, 2);
      wr(pos_ref_pkg::OFS_PPF, 32'(p));
      a = 24'($urandom());
      wr(pos_ref_pkg::OFS_PRESET, {8'h00, a});
      pulse(3 * p, 1'b1);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, a + 24'h000003});
      pulse(p - 1, 1'b1);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, a + 24'h000003});
      wr(pos_ref_pkg::OFS_PRESET, {8'h00, a});
      pulse(1, 1'b0);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, a - 24'h000001});
      wr(pos_ref_pkg::OFS_TRIM, 32'h1);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, a});
      wr(pos_ref_pkg::OFS_TRIM, 32'h2);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, a - 24'h000001});
      wr(pos_ref_pkg::OFS_TRIM, 32'h3);
      rd(pos_ref_pkg::OFS_ADDR, {8'h00, a});
      // Every clock reference, with picture missing on the video input
      src <= 3'h6;
      code(1'b1, 1'b0);
      for (int c = 0; c < 5; c++) begin
         wr(pos_ref_pkg::OFS_CTRL, 32'(c) << 4);
         idle(3);
         chk(6'h01, {5'h00, c != 3});
         rd(pos_ref_pkg::OFS_ADDR, {8'h00, base});
      end
      summarize();
   end
endmodule // positional_reference_selector_tb
`default_nettype wire

// *** verification/transport_model.sv ***
// Behavioural transport feeding time code, pulses and clock sources
`timescale 1ns/1ps
`default_nettype none
module transport_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ltc_on,
   input wire logic vitc_on,
   input wire logic fast,
   input wire logic step,
   input wire logic fwd,
   input wire logic [2:0] src,
   input wire logic [23:0] base,
   output logic ltc_valid,
   output logic [23:0] ltc_addr,
   output logic vitc_valid,
   output logic [23:0] vitc_addr,
   output logic shuttle_fast,
   output logic pulse_tick,
   output logic pulse_fwd,
   output logic pulse_present,
   output logic ref_burst_ok,
   output logic video_in_ok
);
   logic [23:0] junk_q;
   // Readers; a lost reader shows a changing pattern instead of stale code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         junk_q <= 24'h000000;
         {ltc_valid, vitc_valid, shuttle_fast, pulse_tick, pulse_fwd} <= 5'h00;
         {pulse_present, ref_burst_ok, video_in_ok} <= 3'h0;
         ltc_addr <= 24'h000000;
         vitc_addr <= 24'h000000;
      end else begin
         junk_q <= junk_q + 24'h000001;
         ltc_valid <= ltc_on;
         vitc_valid <= vitc_on;
         ltc_addr <= ltc_on ? base : ~junk_q;
         vitc_addr <= vitc_on ? base + 24'h000100 : junk_q;
         shuttle_fast <= fast;
         pulse_tick <= step;
         pulse_fwd <= fwd;
         {pulse_present, ref_burst_ok, video_in_ok} <= src;
      end
   end
endmodule // transport_model
`default_nettype wire
